// File: btg_buzzer_model.sv
// Speaker model timing the pulses seen on the tone pin
module btg_buzzer_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Tone pin, port data bit held at one by software
  input  wire logic        tone_output_pin,
  // Measured pulse lengths in clk cycles, and count of falling edges
  output logic      [31:0] low_len,
  output logic      [31:0] high_len,
  output logic      [31:0] falls
);
  timeunit 1ns;
  timeprecision 1ns;

  logic        last_pin;
  logic [31:0] run_len;

  // Low and high time of each period timed apart
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_pin <= 1'b1;
      run_len  <= 32'h0000_0000;
      low_len  <= 32'h0000_0000;
      high_len <= 32'h0000_0000;
      falls    <= 32'h0000_0000;
    end else begin
      last_pin <= tone_output_pin;
      run_len  <= run_len + 32'h0000_0001;
      if (last_pin && !tone_output_pin) begin
        high_len <= run_len;
        falls    <= falls + 32'h0000_0001;
        run_len  <= 32'h0000_0001;
      end
      if (!last_pin && tone_output_pin) begin
        low_len <= run_len;
        run_len <= 32'h0000_0001;
      end
    end
  end
endmodule : btg_buzzer_model

// File: btg_buzzer_tone_generator.sv
// Buzzer tone generator with APB register slave
module btg_buzzer_tone_generator (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         nrst,
  // APB slave
  input  wire logic [btg_pkg::ADDR_W-1:0]   paddr,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [31:0]                  pwdata,
  input  wire logic [3:0]                   pstrb,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  // Buzzer pin
  output logic                              tone_output_pin
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [6:0] period_of(input logic [2:0] f);
    logic [6:0] base;
    base = 7'd16 + {3'd0, f[1:0], 2'd0};
    period_of = f[2] ? {base[5:0], 1'b0} : base;
  endfunction : period_of

  function automatic logic [6:0] low_of(input logic [2:0] f,
                                        input logic [2:0] lvl);
    logic [6:0] num;
    num = (f[1] ? 7'd12 : 7'd8) - {4'd0, lvl};
    low_of = f[2] ? {num[5:0], 1'b0} : num;
  endfunction : low_of

  function automatic logic hit(input logic [btg_pkg::ADDR_W-1:0] a,
                               input logic [15:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction : hit

  // ****************************************
  // State
  // ****************************************
  logic [24:0] acc;
  logic        fast_tick;
  logic [7:0]  fast_cnt;
  logic        tick256;
  logic        cont_en;
  logic        env_en;
  logic        step_sel;
  logic        width_sel;
  logic [2:0]  freq_sel;
  logic [2:0]  level_sel;
  logic        shot_pend;
  logic        shot_act;
  logic [5:0]  shot_cnt;
  logic [2:0]  env_level;
  logic [5:0]  stage_cnt;
  logic [6:0]  pcnt;
  logic [2:0]  freq_cur;
  logic [2:0]  lvl_cur;

  logic        ctrl_sel;
  logic        tone_sel;
  logic        mapped;
  logic        acc_wr;
  logic        ctrl_wr;
  logic        tone_wr;
  logic        trig_ok;
  logic        stop_wr;
  logic        rst_take;
  logic        cont_rise;
  logic        tone_on;
  logic [2:0]  eff_level;
  logic [5:0]  shot_len;
  logic [5:0]  step_len;
  logic [24:0] next_acc;
  logic [7:0]  ctrl_rd;
  logic [7:0]  tone_rd;

  // ****************************************
  // APB decode
  // ****************************************
  assign ctrl_sel = hit(paddr, btg_pkg::REG_CTRL_IDX);
  assign tone_sel = hit(paddr, btg_pkg::REG_TONE_IDX);
  assign mapped   = ctrl_sel | tone_sel;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~mapped;
  assign acc_wr   = psel & penable & pwrite & pstrb[0];
  assign ctrl_wr  = acc_wr & ctrl_sel;
  assign tone_wr  = acc_wr & tone_sel;

  // Stop beats trigger; trigger dead while continuous tone runs
  assign stop_wr  = ctrl_wr & pwdata[btg_pkg::STOP_BIT]; // see R19
  assign trig_ok  = ctrl_wr & pwdata[btg_pkg::TRIG_BIT]
                    & ~cont_en; // see R16
  assign rst_take = ctrl_wr & pwdata[btg_pkg::ENV_RST_BIT]
                    & env_en; // see R21
  assign cont_rise = ctrl_wr & pwdata[btg_pkg::CONT_BIT] & ~cont_en;

  assign ctrl_rd = {1'b0, 1'b0, shot_pend | shot_act, width_sel,
                    step_sel, 1'b0, env_en, cont_en}; // see R17, R13
  assign tone_rd = {1'b0, level_sel, 1'b0, freq_sel};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h00_0000, ctrl_sel ? ctrl_rd :
                              tone_sel ? tone_rd : 8'h00};
    end
  end

  // ****************************************
  // Register fields
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cont_en   <= btg_pkg::CTRL_RESET[btg_pkg::CONT_BIT];
      step_sel  <= btg_pkg::CTRL_RESET[btg_pkg::STEP_SEL_BIT];
      width_sel <= btg_pkg::CTRL_RESET[btg_pkg::WIDTH_BIT];
    end else if (ctrl_wr) begin
      cont_en   <= pwdata[btg_pkg::CONT_BIT];
      step_sel  <= pwdata[btg_pkg::STEP_SEL_BIT];
      width_sel <= pwdata[btg_pkg::WIDTH_BIT];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      env_en <= btg_pkg::CTRL_RESET[btg_pkg::ENV_EN_BIT];
    end else if (trig_ok) begin
      env_en <= 1'b0; // see R15
    end else if (ctrl_wr) begin
      env_en <= pwdata[btg_pkg::ENV_EN_BIT];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      freq_sel  <= btg_pkg::TONE_RESET[btg_pkg::FREQ_LSB +: 3];
      level_sel <= btg_pkg::TONE_RESET[btg_pkg::LEVEL_LSB +: 3];
    end else if (tone_wr) begin
      freq_sel  <= pwdata[btg_pkg::FREQ_LSB +: 3];
      level_sel <= pwdata[btg_pkg::LEVEL_LSB +: 3];
    end
  end

  // ****************************************
  // Fast tick and 256 Hz tick
  // ****************************************
  // Phase accumulator averages to twice the low-speed rate
  assign next_acc = acc + btg_pkg::DDS_STEP;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc       <= 25'd0;
      fast_tick <= 1'b0;
    end else if (next_acc >= btg_pkg::DDS_MOD) begin
      acc       <= next_acc - btg_pkg::DDS_MOD;
      fast_tick <= 1'b1;
    end else begin
      acc       <= next_acc;
      fast_tick <= 1'b0;
    end
  end

  assign tick256 = fast_tick && (fast_cnt == btg_pkg::FAST_PER_TICK_M1);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fast_cnt <= 8'd0;
    end else if (fast_tick) begin
      fast_cnt <= fast_cnt + 8'd1;
    end
  end

  // ****************************************
  // One-shot
  // ****************************************
  assign shot_len = width_sel ? btg_pkg::SHOT_LONG_TICKS
                              : btg_pkg::SHOT_SHORT_TICKS; // see R11

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shot_pend <= 1'b0;
      shot_act  <= 1'b0;
      shot_cnt  <= 6'd0;
    end else if (stop_wr) begin
      shot_pend <= 1'b0; // see R14, R20
      shot_act  <= 1'b0;
    end else if (trig_ok) begin
      shot_cnt <= 6'd0; // see R18
      if (!shot_act) begin
        shot_pend <= 1'b1;
      end
    end else if (tick256) begin
      if (shot_pend) begin
        shot_pend <= 1'b0; // see R12
        shot_act  <= 1'b1;
        shot_cnt  <= 6'd0;
      end else if (shot_act) begin
        if (shot_cnt == shot_len - 6'd1) begin
          shot_act <= 1'b0; // see R12
        end else begin
          shot_cnt <= shot_cnt + 6'd1;
        end
      end
    end
  end

  // ****************************************
  // Envelope
  // ****************************************
  assign step_len = step_sel ? btg_pkg::STEP_LONG_TICKS
                             : btg_pkg::STEP_SHORT_TICKS; // see R10

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      env_level <= 3'd0;
      stage_cnt <= 6'd0;
    end else if (cont_rise || rst_take) begin
      env_level <= 3'd0; // see R07, R09
      stage_cnt <= 6'd0;
    end else if (tick256 && env_en && cont_en) begin
      if (stage_cnt == step_len - 6'd1) begin
        stage_cnt <= 6'd0;
        if (env_level != btg_pkg::LEVEL_MIN) begin
          env_level <= env_level + 3'd1; // see R07
        end
      end else begin
        stage_cnt <= stage_cnt + 6'd1;
      end
    end
  end

  // ****************************************
  // Tone waveform
  // ****************************************
  assign tone_on   = cont_en | shot_act; // see R01
  assign eff_level = env_en ? env_level : level_sel; // see R08

  // New selects are taken only at a period start
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pcnt     <= 7'd0;
      freq_cur <= 3'd0;
      lvl_cur  <= 3'd0;
    end else if (!tone_on) begin
      pcnt     <= 7'd0;
      freq_cur <= freq_sel;
      lvl_cur  <= eff_level;
    end else if (fast_tick) begin
      if (pcnt == period_of(freq_cur) - 7'd1) begin
        pcnt     <= 7'd0; // see R04, R22
        freq_cur <= freq_sel;
        lvl_cur  <= eff_level;
      end else begin
        pcnt <= pcnt + 7'd1;
      end
    end
  end

  // Low phase first, then high for the rest of the period
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tone_output_pin <= 1'b1;
    end else begin
      tone_output_pin <= ~(tone_on && // see R02, R05, R06
                           (pcnt < low_of(freq_cur, lvl_cur)));
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_idle_out_high: assert property ( // see R02
    @(posedge clk) disable iff (!nrst)
    !tone_on |=> tone_output_pin)
    else $error("tone output not high while idle");

  a_shot_start_tick: assert property ( // see R12
    @(posedge clk) disable iff (!nrst)
    $rose(shot_act) |-> $past(tick256))
    else $error("one-shot started off the 256 Hz tick");

  a_shot_end_tick: assert property ( // see R12
    @(posedge clk) disable iff (!nrst)
    $fell(shot_act) && !$past(stop_wr) |-> $past(tick256))
    else $error("one-shot ended off the 256 Hz tick");

  a_stop_ends_shot: assert property ( // see R14
    @(posedge clk) disable iff (!nrst)
    stop_wr |=> !shot_act && !shot_pend ##1 tone_output_pin)
    else $error("forced stop did not end one-shot");

  a_trig_while_cont: assert property ( // see R16
    @(posedge clk) disable iff (!nrst)
    ctrl_wr && pwdata[btg_pkg::TRIG_BIT] && cont_en && !shot_pend
    && !shot_act |=> !shot_pend && !shot_act)
    else $error("trigger accepted during continuous tone");

  a_trig_clears_env: assert property ( // see R15
    @(posedge clk) disable iff (!nrst)
    trig_ok |=> !env_en)
    else $error("trigger did not clear envelope enable");

  a_env_restart: assert property ( // see R09
    @(posedge clk) disable iff (!nrst)
    rst_take |=> env_level == 3'd0)
    else $error("envelope restart did not return to level 1");

  a_env_hold_min: assert property ( // see R07
    @(posedge clk) disable iff (!nrst)
    env_level == btg_pkg::LEVEL_MIN && !cont_rise && !rst_take
    |=> env_level == btg_pkg::LEVEL_MIN)
    else $error("envelope left the minimum level");

  a_select_latch: assert property ( // see R22
    @(posedge clk) disable iff (!nrst)
    tone_on && $past(tone_on) && pcnt != 7'd0
    |-> $stable(freq_cur) && $stable(lvl_cur))
    else $error("selects changed inside a tone period");

  a_busy_readback: assert property ( // see R13, R21
    @(posedge clk) disable iff (!nrst)
    psel && !penable && !pwrite && ctrl_sel
    |=> prdata[btg_pkg::TRIG_BIT] == $past(shot_pend | shot_act)
        && !prdata[btg_pkg::ENV_RST_BIT])
    else $error("busy status read back wrong");

endmodule : btg_buzzer_tone_generator

// File: btg_buzzer_tone_generator_tb.sv
// Self-checking testbench of the buzzer tone generator
module btg_buzzer_tone_generator_tb;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [17:0] A_CTRL = {btg_pkg::REG_CTRL_IDX, 2'b00};
  localparam logic [17:0] A_TONE = {btg_pkg::REG_TONE_IDX, 2'b00};
  localparam logic [17:0] A_NONE = 18'h0_0010;

  logic        clk;
  logic        nrst;
  logic [17:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        tone_output_pin;
  logic [31:0] low_len;
  logic [31:0] high_len;
  logic [31:0] falls;
  logic [31:0] r;
  logic [31:0] base;
  logic        e;
  logic [2:0]  fs [3];
  logic [2:0]  ls [3];
  int          mismatches;
  int          cmp_count;
  int          k;

  btg_buzzer_tone_generator dut (
    .clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tone_output_pin(tone_output_pin)
  );

  btg_buzzer_model spk (
    .clk(clk), .nrst(nrst), .tone_output_pin(tone_output_pin),
    .low_len(low_len), .high_len(high_len), .falls(falls)
  );

  // ****************************************
  // Checking and expectations
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [31:0] clks(int t);
    return (t * btg_pkg::CLK_HZ + btg_pkg::FAST_HZ / 2) / btg_pkg::FAST_HZ;
  endfunction : clks

  // Phase accumulator jitter of two clk cycles tolerated
  function automatic logic [31:0] near(logic [31:0] m, logic [31:0] x);
    return (m + 2 >= x && m <= x + 2) ? x : m;
  endfunction : near

  task automatic tally_and_finish;
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  // ****************************************
  // APB master
  // ****************************************
  task automatic apb(input logic wr, input logic [17:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd_chk(input logic [17:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, x);
  endtask : rd_chk

  // Time one full period with the given selects
  task automatic meas(input logic [2:0] f, input logic [2:0] l);
    logic [31:0] xl;
    logic [31:0] xp;
    xl = clks(((f[1] ? 12 : 8) - l) << f[2]);
    xp = clks((16 + 4 * f[1:0]) << f[2]);
    base = falls;
    k = 0;
    while (falls - base < 2 && k < 30000) begin
      @(posedge clk);
      k++;
    end
    chk(32'(k < 30000), 32'h0000_0001);
    chk(near(low_len, xl), xl);
    chk(near(low_len + high_len, xp), xp);
  endtask : meas

  // ****************************************
  // Clock, watchdog and tests
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h0_0000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    mismatches = 0;
    cmp_count = 0;
    r = $urandom(59);
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(A_CTRL, 32'h0000_0000);
    rd_chk(A_TONE, 32'h0000_0000);
    chk(32'(tone_output_pin), 32'h0000_0001);
    $display("Test reset done");
    base = $urandom;
    wr(A_TONE, base);
    rd_chk(A_TONE, base & 32'h0000_0077);
    pstrb <= 4'hE;
    wr(A_TONE, ~base);
    pstrb <= 4'hF;
    rd_chk(A_TONE, base & 32'h0000_0077);
    apb(1'b1, A_NONE, 32'h0000_00FF, r, e);
    chk(32'(e), 32'h0000_0001);
    apb(1'b0, A_NONE, 32'h0000_0000, r, e);
    chk({r[31:1], e}, 32'h0000_0001);
    wr(A_CTRL, 32'h0000_001C);
    rd_chk(A_CTRL, 32'h0000_0018);
    $display("Test registers done");
    fs = '{3'h0, 3'h7, 3'($urandom)};
    ls = '{3'h0, 3'h7, 3'($urandom)};
    wr(A_CTRL, 32'h0000_0001);
    for (int i = 0; i < 3; i++) begin
      wr(A_TONE, {25'h0, ls[i], 1'b0, fs[i]});
      meas(fs[i], ls[i]);
    end
    $display("Test tone done");
    wr(A_TONE, {25'h0, 3'h7, 1'b0, 3'h1});
    wr(A_CTRL, 32'h0000_0007);
    rd_chk(A_CTRL, 32'h0000_0003);
    meas(3'h1, 3'h0);
    wr(A_CTRL, 32'h0000_0023);
    rd_chk(A_CTRL, 32'h0000_0003);
    wr(A_CTRL, 32'h0000_0007);
    rd_chk(A_CTRL, 32'h0000_0003);
    $display("Test envelope done");
    wr(A_CTRL, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk(32'(tone_output_pin), 32'h0000_0001);
    base = falls;
    repeat (3000) @(posedge clk);
    chk(falls - base, 32'h0000_0000);
    $display("Test off done");
    wr(A_CTRL, 32'h0000_0022);
    rd_chk(A_CTRL, 32'h0000_0020);
    k = 0;
    while (tone_output_pin !== 1'b0 && k < 40000) begin
      @(posedge clk);
      k++;
    end
    chk(32'(tone_output_pin), 32'h0000_0000);
    wr(A_CTRL, 32'h0000_0020);
    rd_chk(A_CTRL, 32'h0000_0020);
    wr(A_CTRL, 32'h0000_0040);
    repeat (2) @(posedge clk);
    chk(32'(tone_output_pin), 32'h0000_0001);
    rd_chk(A_CTRL, 32'h0000_0000);
    wr(A_CTRL, 32'h0000_0040);
    rd_chk(A_CTRL, 32'h0000_0000);
    wr(A_CTRL, 32'h0000_0060);
    rd_chk(A_CTRL, 32'h0000_0000);
    $display("Test one-shot done");
    tally_and_finish();
  end
endmodule : btg_buzzer_tone_generator_tb

// File: btg_pkg.sv
// Constants for the buzzer tone generator
// Overview of operation
// R01: Drive tone when continuous or one-shot active
// R02: Otherwise or on stop hold output high
// R03: Software keeps port data bit at one
// R04: Eight tone frequencies divided from 32.768 kHz
// R05: Level code lowers duty numerator per step
// R06: Duty is low time over whole period
// R07: Envelope steps level 1 to 8, holds
// R08: Envelope level overrides level select field
// R09: Envelope restart returns to level 1
// R10: Step interval 125 or 62.5 msec
// R11: One-shot length 125 or 31.25 msec
// R12: One-shot starts and stops on 256 Hz
// R13: Trigger bit reads busy status
// R14: Stop ends one-shot at once, output high
// R15: Trigger write clears envelope enable
// R16: Trigger ignored while continuous enable set
// R17: Control byte field order, top bit zero
// R18: Retrigger restarts the duration measurement
// R19: Stop beats trigger in same write
// R20: Stop while idle does nothing
// R21: Restart ignored without envelope, reads zero
// R22: Selects change only at period boundary
package btg_pkg;

  // ****************************************
  // Clock and tick rates
  // ****************************************
  localparam int unsigned   CLK_HZ      = 10_000_000;
  localparam int unsigned   OSC_HZ      = 32_768;
  localparam int unsigned   FAST_HZ     = 2 * OSC_HZ;
  localparam logic [24:0]   DDS_MOD     = 25'(CLK_HZ);
  localparam logic [24:0]   DDS_STEP    = 25'(FAST_HZ);
  localparam int unsigned   TICK_HZ     = 256;
  localparam logic [7:0]    FAST_PER_TICK_M1 = 8'(FAST_HZ / TICK_HZ - 1);

  // ****************************************
  // Times and derived tick counts
  // ****************************************
  localparam int unsigned   STEP_SHORT_US = 62_500;
  localparam int unsigned   STEP_LONG_US  = 125_000;
  localparam int unsigned   SHOT_SHORT_US = 31_250;
  localparam int unsigned   SHOT_LONG_US  = 125_000;
  localparam logic [5:0]    STEP_SHORT_TICKS =
    6'(STEP_SHORT_US * TICK_HZ / 1_000_000);
  localparam logic [5:0]    STEP_LONG_TICKS =
    6'(STEP_LONG_US * TICK_HZ / 1_000_000);
  localparam logic [5:0]    SHOT_SHORT_TICKS =
    6'((SHOT_SHORT_US * TICK_HZ + 999_999) / 1_000_000);
  localparam logic [5:0]    SHOT_LONG_TICKS =
    6'((SHOT_LONG_US * TICK_HZ + 999_999) / 1_000_000);

  // ****************************************
  // Register map (index, byte address is four times)
  // ****************************************
  localparam int unsigned   ADDR_W       = 18;
  localparam logic [15:0]   REG_CTRL_IDX = 16'hff54;
  localparam logic [15:0]   REG_TONE_IDX = 16'hff55;
  localparam int unsigned   CONT_BIT     = 0;
  localparam int unsigned   ENV_EN_BIT   = 1;
  localparam int unsigned   ENV_RST_BIT  = 2;
  localparam int unsigned   STEP_SEL_BIT = 3;
  localparam int unsigned   WIDTH_BIT    = 4;
  localparam int unsigned   TRIG_BIT     = 5;
  localparam int unsigned   STOP_BIT     = 6;
  localparam int unsigned   FREQ_LSB     = 0;
  localparam int unsigned   LEVEL_LSB    = 4;
  localparam logic [7:0]    CTRL_RESET   = 8'h00;
  localparam logic [7:0]    TONE_RESET   = 8'h00;
  localparam logic [2:0]    LEVEL_MIN    = 3'h7;

endpackage : btg_pkg
